// File: rtl/scg_bank.sv
// Secondary clock gate register and system error cause register of the bridge.
`timescale 1ns/1ps
`default_nettype none
module scg_bank #(
    parameter int NUM_SCLK  = scg_pkg::NUM_SCLK,
    parameter int NUM_CAUSE = scg_pkg::NUM_CAUSE
) (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    clk_en,
    input  wire logic                    sec_bus_rst,
    input  wire logic                    cfg_wr,
    input  wire logic                    cfg_rd,
    input  wire logic [7:0]              cfg_addr,
    input  wire logic [3:0]              cfg_be_n,
    input  wire logic [31:0]             cfg_wdata,
    output logic      [31:0]             cfg_rdata,
    output logic                         cfg_rd_valid,
    input  wire logic [NUM_CAUSE-1:0]    err_event,
    input  wire logic [NUM_CAUSE-2:0]    err_mask,
    input  wire logic                    serr_enable,
    output logic                         sys_err_n_out,
    output logic                         sys_err_oe,
    output logic      [NUM_SCLK-1:0]     sec_clk_out
);
    // The field layout is fixed; other counts cannot be served.
    if (NUM_SCLK != scg_pkg::NUM_SCLK || NUM_CAUSE != scg_pkg::NUM_CAUSE)
    begin : g_bad_param
        $error("scg_bank serves only five clocks and eight causes.");
    end

    // Width of the four pair fields that share the low byte lane.
    localparam int PAIR_BITS = scg_pkg::NUM_PAIR * scg_pkg::PAIR_W;

    typedef struct packed {
        logic [scg_pkg::GATE_BITS-1:0] gate;
        logic [31:0]                   rdata;
        logic                          rvalid;
        logic                          serr_oe;
    } scg_bank_st_t;

    scg_bank_st_t           st_reg;
    scg_bank_st_t           st_next;
    logic                   dword_hit;
    logic                   cause_wr;
    logic [NUM_CAUSE-1:0]   cause_flags;
    logic [NUM_CAUSE-1:0]   cause_set;
    logic [NUM_CAUSE-1:0]   cause_clr;
    logic [NUM_SCLK-1:0]    clk_stop;
    logic [NUM_CAUSE-1:0]   cause_open;

    // Both registers share one dword; the byte enables pick the register.
    assign dword_hit = (cfg_addr[7:2] == scg_pkg::REG_DWORD_OFF[7:2]);
    assign cause_wr  = cfg_wr && dword_hit && !cfg_be_n[scg_pkg::CAUSE_LANE];

    // An event latches its cause only when it actually drives the error output.
    // The master time-out cause has no mask, so it qualifies whenever serr_enable is set.
    assign cause_set = err_event
                     & {1'b1, ~err_mask}
                     & {NUM_CAUSE{serr_enable}};
    assign cause_clr = {NUM_CAUSE{cause_wr}}
                     & cfg_wdata[scg_pkg::CAUSE_LO +: NUM_CAUSE];

    scg_cause_flags #(
        .N       (NUM_CAUSE)
    ) u_cause (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .set_evt (cause_set),
        .clr     (cause_clr),
        .flags   (cause_flags)
    );

    // Stop requests: pairs need both bits set, the last clock uses a single bit.
    for (genvar i = 0; i < NUM_SCLK; i++)
    begin : g_sclk
        if (i < scg_pkg::NUM_PAIR)
        begin : g_pair
            assign clk_stop[i] = &st_reg.gate[i*scg_pkg::PAIR_W +: scg_pkg::PAIR_W];

            // A closed pair must leave its output parked high within two edges.
            property p_pair_high;
                @(posedge sys_clk) disable iff (!arst_n || !clk_en)
                (&st_reg.gate[i*scg_pkg::PAIR_W +: scg_pkg::PAIR_W]) [*3] |-> sec_clk_out[i];
            endproperty
            a_pair_high: assert property (p_pair_high) else $error("Pair clock not high.");

            // Either bit of a pair at zero keeps the output toggling on every edge.
            property p_pair_run;
                @(posedge sys_clk) disable iff (!arst_n || !clk_en)
                (!(&st_reg.gate[i*scg_pkg::PAIR_W +: scg_pkg::PAIR_W])) [*4]
                |-> (sec_clk_out[i] != $past(sec_clk_out[i]));
            endproperty
            a_pair_run: assert property (p_pair_run) else $error("Open pair clock stuck.");
        end
        else
        begin : g_single
            assign clk_stop[i] = st_reg.gate[scg_pkg::CLK4_BIT];

            // Clock 4 with its bit at zero keeps toggling on every edge.
            property p_clk4_run;
                @(posedge sys_clk) disable iff (!arst_n || !clk_en)
                (!st_reg.gate[scg_pkg::CLK4_BIT]) [*4]
                |-> (sec_clk_out[i] != $past(sec_clk_out[i]));
            endproperty
            a_clk4_run: assert property (p_clk4_run) else $error("Open clock 4 stuck.");
        end

        scg_clk_gate u_gate (
            .sys_clk  (sys_clk),
            .arst_n   (arst_n),
            .clk_en   (clk_en),
            .stop_req (clk_stop[i]),
            .sclk_out (sec_clk_out[i])
        );
    end

    // Register writes, read answer and the error output drive.
    always_comb
    begin
        st_next = st_reg;
        if (sec_bus_rst)
        begin
            st_next.gate = scg_pkg::GATE_RST;
        end
        else if (cfg_wr && dword_hit)
        begin
            if (!cfg_be_n[scg_pkg::GATE_LANE_LO])
            begin
                st_next.gate[PAIR_BITS-1:0] = cfg_wdata[PAIR_BITS-1:0];
            end
            if (!cfg_be_n[scg_pkg::GATE_LANE_HI])
            begin
                st_next.gate[scg_pkg::CLK4_BIT] = cfg_wdata[scg_pkg::CLK4_BIT];
            end
        end
        st_next.rvalid = cfg_rd;
        if (cfg_rd)
        begin
            if (dword_hit)
            begin
                st_next.rdata = {8'h00, cause_flags, 2'h0,
                                 scg_pkg::RSVD_VAL, st_reg.gate};
            end
            else
            begin
                st_next.rdata = scg_pkg::UNMAPPED_DATA;
            end
        end
        // One-cycle open-drain pulse per qualified event, as the bus expects.
        st_next.serr_oe = |cause_set;
    end

    // Bank state register.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '{gate: scg_pkg::GATE_RST, rdata: 32'h0000_0000,
                        rvalid: 1'b0, serr_oe: 1'b0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign cfg_rdata     = st_reg.rdata;
    assign cfg_rd_valid  = st_reg.rvalid;
    assign sys_err_oe    = st_reg.serr_oe;
    assign sys_err_n_out = 1'b0;

    property p_gate_rst;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        sec_bus_rst |=> (st_reg.gate == scg_pkg::GATE_RST);
    endproperty
    a_gate_rst: assert property (p_gate_rst) else $error("Gate bits survived bus reset.");

    property p_rsvd_ones;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_rd && dword_hit)
        |=> (cfg_rd_valid && cfg_rdata[scg_pkg::RSVD_LO +: scg_pkg::RSVD_W] == scg_pkg::RSVD_VAL);
    endproperty
    a_rsvd_ones: assert property (p_rsvd_ones) else $error("Reserved bits not ones.");

    property p_serr_drive;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (serr_enable && |(err_event & {1'b1, ~err_mask})) |=> sys_err_oe;
    endproperty
    a_serr_drive: assert property (p_serr_drive) else $error("Error output not driven.");

    property p_serr_quiet;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (!serr_enable || !(|(err_event & {1'b1, ~err_mask}))) |=> !sys_err_oe;
    endproperty
    a_serr_quiet: assert property (p_serr_quiet) else $error("Error output driven wrongly.");

    property p_clk4_stop;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_wr && dword_hit && !cfg_be_n[scg_pkg::GATE_LANE_HI]
            && cfg_wdata[scg_pkg::CLK4_BIT] && !sec_bus_rst)
        ##1 (st_reg.gate[scg_pkg::CLK4_BIT] && !sec_bus_rst) [*4]
        |-> sec_clk_out[scg_pkg::NUM_PAIR];
    endproperty
    a_clk4_stop: assert property (p_clk4_stop) else $error("Clock 4 not held high.");

    // Pair fields follow a lane 0 write one edge later; bus reset has priority.
    property p_gate_write;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_wr && dword_hit && !cfg_be_n[scg_pkg::GATE_LANE_LO] && !sec_bus_rst)
        |=> (st_reg.gate[PAIR_BITS-1:0] == $past(cfg_wdata[PAIR_BITS-1:0]));
    endproperty
    a_gate_write: assert property (p_gate_write) else $error("Pair fields not written.");

    // The clock 4 bit follows a lane 1 write; the bits above it have no storage.
    property p_clk4_write;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_wr && dword_hit && !cfg_be_n[scg_pkg::GATE_LANE_HI] && !sec_bus_rst)
        |=> (st_reg.gate[scg_pkg::CLK4_BIT] == $past(cfg_wdata[scg_pkg::CLK4_BIT]));
    endproperty
    a_clk4_write: assert property (p_clk4_write) else $error("Clock 4 bit not written.");

    // A write with lane 0 switched off must leave the pair fields alone.
    property p_lane_off;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_wr && cfg_be_n[scg_pkg::GATE_LANE_LO] && !sec_bus_rst)
        |=> $stable(st_reg.gate[PAIR_BITS-1:0]);
    endproperty
    a_lane_off: assert property (p_lane_off) else $error("Disabled lane written.");

    // Writes to any other dword are refused, so no gate bit may move.
    property p_unmapped_write;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_wr && !dword_hit && !sec_bus_rst) |=> $stable(st_reg.gate);
    endproperty
    a_unmapped_write: assert property (p_unmapped_write) else $error("Stray write landed.");

    // The cause byte read back is the flag state at the request edge.
    property p_cause_read;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_rd && dword_hit)
        |=> (cfg_rdata[scg_pkg::CAUSE_LO +: NUM_CAUSE] == $past(cause_flags));
    endproperty
    a_cause_read: assert property (p_cause_read) else $error("Cause byte misread.");

    // Read valid is the read strobe delayed by exactly one edge.
    property p_rd_pulse;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        1'b1 |=> (cfg_rd_valid == $past(cfg_rd));
    endproperty
    a_rd_pulse: assert property (p_rd_pulse) else $error("Read valid misplaced.");

    // Read data holds between requests, so software may take it late.
    property p_rdata_hold;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        !cfg_rd |=> $stable(cfg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved.");

    // Every other dword reads back as zero.
    property p_unmapped_read;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (cfg_rd && !dword_hit) |=> (cfg_rdata == scg_pkg::UNMAPPED_DATA);
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Stray read not zero.");

    // Without a clearing write no cause bit may drop; a bus reset leaves them too.
    property p_no_drop;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        !cause_wr |=> ((cause_flags & $past(cause_flags)) == $past(cause_flags));
    endproperty
    a_no_drop: assert property (p_no_drop) else $error("Cause bit dropped.");

    // Qualification rebuilt apart from the datapath, so the checks below stand alone.
    assign cause_open = {1'b1, ~err_mask} & {NUM_CAUSE{serr_enable}};

    // Per cause: a qualified event latches its bit, and a bit only rises with the drive.
    for (genvar c = 0; c < NUM_CAUSE; c++)
    begin : g_cause_chk
        property p_cause_latch;
            @(posedge sys_clk) disable iff (!arst_n || !clk_en)
            (err_event[c] && cause_open[c]) |=> cause_flags[c];
        endproperty
        a_cause_latch: assert property (p_cause_latch) else $error("Cause not latched.");

        property p_cause_drive;
            @(posedge sys_clk) disable iff (!arst_n || !clk_en)
            $rose(cause_flags[c]) |-> sys_err_oe;
        endproperty
        a_cause_drive: assert property (p_cause_drive) else $error("Cause without drive.");
    end
endmodule : scg_bank
`default_nettype wire

// File: rtl/scg_pkg.sv
// Package with offsets, field layout and reset values of the clock gate and error cause bank.
package scg_pkg;
    // Configuration dword that holds both registers, and the byte lane of the cause byte.
    localparam logic [7:0] REG_DWORD_OFF   = 8'h68;
    localparam logic [7:0] CAUSE_BYTE_OFF  = 8'h6a;
    localparam int         CAUSE_LANE      = 2;
    localparam int         GATE_LANE_LO    = 0;
    localparam int         GATE_LANE_HI    = 1;
    // Clock gate field layout.
    localparam int         NUM_SCLK        = 5;
    localparam int         NUM_PAIR        = 4;
    localparam int         PAIR_W          = 2;
    localparam int         GATE_BITS       = 9;
    localparam int         CLK4_BIT        = 8;
    localparam int         RSVD_LO         = 9;
    localparam int         RSVD_W          = 5;
    localparam int         CAUSE_LO        = 16;
    // Error cause layout; the master time-out cause has no mask bit.
    localparam int         NUM_CAUSE       = 8;
    localparam int         NUM_MASKED      = 7;
    // Reset and read-back values.
    localparam logic [8:0] GATE_RST        = 9'h000;
    localparam logic [7:0] CAUSE_RST       = 8'h00;
    localparam logic [4:0] RSVD_VAL        = 5'h1f;
    localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
endpackage : scg_pkg

// File: rtl/scg_clk_gate.sv
// One gated secondary clock output running at half the system clock rate.
`timescale 1ns/1ps
`default_nettype none
module scg_clk_gate (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    input  wire logic stop_req,
    output logic      sclk_out
);
    typedef struct packed {
        logic phase;
        logic run;
        logic out;
    } scg_gate_st_t;

    scg_gate_st_t st_reg;
    scg_gate_st_t st_next;

    // The run flag only changes while the output is high, so a start or stop never
    // cuts a pulse short; the price is up to one extra cycle of latency.
    always_comb
    begin
        st_next       = st_reg;
        st_next.phase = ~st_reg.phase;
        if (st_reg.phase)
        begin
            st_next.run = ~stop_req;
        end
        st_next.out   = st_next.phase | ~st_next.run;
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '{phase: 1'b0, run: 1'b1, out: 1'b0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign sclk_out = st_reg.out;

    property p_edge_high;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        ($changed(st_reg.run)) |-> $past(st_reg.out);
    endproperty
    a_edge_high: assert property (p_edge_high) else $error("Gate changed while low.");

    property p_stop_high;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        stop_req [*3] |-> sclk_out;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("Stopped clock not high.");

    property p_run_toggle;
        @(posedge sys_clk) disable iff (!arst_n || !clk_en)
        (!stop_req) [*4] |-> (sclk_out != $past(sclk_out));
    endproperty
    a_run_toggle: assert property (p_run_toggle) else $error("Running clock stuck.");
endmodule : scg_clk_gate
`default_nettype wire

// File: rtl/scg_cause_flags.sv
// Sticky write-one-to-clear cause flags where a new event wins over a clear.
`timescale 1ns/1ps
`default_nettype none
module scg_cause_flags #(
    parameter int N = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic         clk_en,
    input  wire logic [N-1:0] set_evt,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] flags
);
    typedef struct packed {
        logic [N-1:0] flags;
    } scg_flag_st_t;

    scg_flag_st_t st_reg;
    scg_flag_st_t st_next;
    logic [N-1:0] bit_next;

    // Per flag: the set term is or-ed after the clear so a same-cycle event survives.
    for (genvar i = 0; i < N; i++)
    begin : g_flag
        assign bit_next[i] = set_evt[i] | (st_reg.flags[i] & ~clr[i]);

        property p_set_wins;
            @(posedge sys_clk) disable iff (!arst_n || !clk_en)
            set_evt[i] |=> flags[i];
        endproperty
        a_set_wins: assert property (p_set_wins) else $error("Cause flag not set.");

        property p_clear;
            @(posedge sys_clk) disable iff (!arst_n || !clk_en)
            (clr[i] && !set_evt[i]) |=> !flags[i];
        endproperty
        a_clear: assert property (p_clear) else $error("Cause flag not cleared.");

        property p_hold;
            @(posedge sys_clk) disable iff (!arst_n || !clk_en)
            (!clr[i] && !set_evt[i]) |=> $stable(flags[i]);
        endproperty
        a_hold: assert property (p_hold) else $error("Cause flag moved alone.");
    end

    // Next-state copy.
    always_comb
    begin
        st_next       = st_reg;
        st_next.flags = bit_next;
    end

    // Flag register.
    always_ff @(posedge sys_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_reg <= '{flags: '0};
        end
        else if (clk_en)
        begin
            st_reg <= st_next;
        end
    end

    assign flags = st_reg.flags;
endmodule : scg_cause_flags
`default_nettype wire

// File: sim/scg_slot_model.sv
// Secondary bus slot model that counts rising edges on each gated clock.
`timescale 1ns/1ps
`default_nettype none
module scg_slot_model (
    input  wire logic [4:0] sclk,
    output int              rises [5]
);
    // Edge counters only grow, so the bench looks at differences across a window.
    for (genvar k = 0; k < 5; k++)
    begin : g_slot
        initial rises[k] = 0;
        always @(posedge sclk[k]) rises[k] = rises[k] + 1;
    end
endmodule : scg_slot_model
`default_nettype wire

// File: sim/scg_bank_tb.sv
// Self-checking bench for the clock gate and error cause bank.
`timescale 1ns/1ps
`default_nettype none
module scg_bank_tb;
    typedef struct {logic [8:0] g; logic [4:0] stop;} scg_row_t;
    logic        sys_clk, arst_n, sec_bus_rst, cfg_wr, cfg_rd, serr_enable;
    logic [7:0]  cfg_addr, err_event;
    logic [3:0]  cfg_be_n;
    logic [31:0] cfg_wdata, cfg_rdata;
    logic        cfg_rd_valid, sys_err_n_out, sys_err_oe;
    logic [6:0]  err_mask;
    logic [4:0]  sec_clk_out;
    int          rises [5];
    int          snap [5];
    int          bad_count, tests_run;
    scg_row_t    rows [8] = '{'{9'h000, 5'h00}, '{9'h003, 5'h01}, '{9'h001, 5'h00},
        '{9'h00c, 5'h02}, '{9'h030, 5'h04}, '{9'h0c0, 5'h08}, '{9'h100, 5'h10},
        '{9'h1ff, 5'h1f}};

    scg_bank i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
        .sec_bus_rst(sec_bus_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_be_n(cfg_be_n), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rd_valid(cfg_rd_valid), .err_event(err_event), .err_mask(err_mask),
        .serr_enable(serr_enable), .sys_err_n_out(sys_err_n_out), .sys_err_oe(sys_err_oe),
        .sec_clk_out(sec_clk_out));
    scg_slot_model i_slot (.sclk(sec_clk_out), .rises(rises));

    // The clock is kept apart from stimulus so the watchdog can share it.
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // Expected dword: gates low, fixed ones above them, causes in lane 2.
    function automatic logic [31:0] dw(logic [8:0] g, logic [7:0] c);
        return {8'h00, c, 2'b00, scg_pkg::RSVD_VAL, g};
    endfunction : dw

    task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk32

    task automatic chk1(string n, logic e, logic g);
        chk32(n, {31'h0, e}, {31'h0, g});
    endtask : chk1

    // One write strobe with every qualifier held across the sampling edge.
    task automatic wr(logic [7:0] a, logic [3:0] be, logic [31:0] d, logic [7:0] ev);
        @(negedge sys_clk);
        {cfg_wr, cfg_addr, cfg_be_n, cfg_wdata, err_event} = {1'b1, a, be, d, ev};
        @(negedge sys_clk);
        {cfg_wr, err_event} = 9'h000;
    endtask : wr

    // Read is answered at the edge after the strobe, so it is checked one half cycle on.
    task automatic rd_chk(logic [7:0] a, logic [31:0] e);
        @(negedge sys_clk);
        {cfg_rd, cfg_addr} = {1'b1, a};
        @(negedge sys_clk);
        cfg_rd = 1'b0;
        chk1("rd_valid", 1'b1, cfg_rd_valid);
        chk32("rdata", e, cfg_rdata);
    endtask : rd_chk

    // An event pulse must drive system error one cycle later only when allowed.
    task automatic ev_chk(logic [7:0] ev, logic e);
        wr(8'h00, 4'hf, 32'h0, ev);
        chk1("sys_err_oe", e, sys_err_oe);
        chk1("sys_err_n_out", 1'b0, sys_err_n_out);
    endtask : ev_chk

    // One-cycle secondary bus reset pulse, driven off the sampling edge.
    task automatic sbr;
        @(negedge sys_clk);
        sec_bus_rst = 1'b1;
        @(negedge sys_clk);
        sec_bus_rst = 1'b0;
    endtask : sbr

    task automatic stop_test;
        $display("Checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    initial
    begin
        repeat (6000) @(posedge sys_clk);
        bad_count++;
        stop_test();
    end

    initial
    begin
        {arst_n, sec_bus_rst, cfg_wr, cfg_rd, serr_enable} = 5'b00001;
        {cfg_addr, err_event, cfg_be_n, cfg_wdata, err_mask} = '0;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        rd_chk(8'h68, dw(9'h000, 8'h00));
        $display("Test reset values done");
        // Gate table: bits 15:9 written high must not stick.
        foreach (rows[r])
        begin
            wr(8'h68, 4'b1100, {16'h0, 7'h7f, rows[r].g}, 8'h00);
            rd_chk(8'h68, dw(rows[r].g, 8'h00));
            repeat (4) @(negedge sys_clk);
            snap = rises;
            repeat (8) @(negedge sys_clk);
            for (int k = 0; k < 5; k++)
            begin
                chk32("rises", rows[r].stop[k] ? 0 : 4, rises[k] - snap[k]);
                if (rows[r].stop[k])
                    chk1("clk_high", 1'b1, sec_clk_out[k]);
            end
        end
        $display("Test gate table done");
        // Secondary bus reset reopens every gate and all five clocks run again.
        sbr();
        rd_chk(8'h68, dw(9'h000, 8'h00));
        snap = rises;
        repeat (8) @(negedge sys_clk);
        for (int k = 0; k < 5; k++)
            chk32("rises_sbr", 4, rises[k] - snap[k]);
        $display("Test bus reset done");
        // Each cause bit in turn, accumulating.
        for (int i = 0; i < 8; i++)
        begin
            ev_chk(8'h01 << i, 1'b1);
            rd_chk(8'h6a, dw(9'h0, 8'hff >> (7 - i)));
        end
        // Clear the low nibble while bit 0 fires again in the same cycle.
        wr(8'h68, 4'b1011, 32'h000f_0000, 8'h01);
        rd_chk(8'h68, dw(9'h0, 8'hf1));
        wr(8'h68, 4'b1011, 32'h00ff_0000, 8'h00);
        $display("Test causes done");
        // Masked events stay silent; the time-out cause has no mask.
        err_mask = 7'h7f;
        ev_chk(8'h7f, 1'b0);
        ev_chk(8'h80, 1'b1);
        err_mask = 7'h00;
        serr_enable = 1'b0;
        ev_chk(8'hff, 1'b0);
        rd_chk(8'h68, dw(9'h0, 8'h80));
        $display("Test masking done");
        // Unmapped dword ignores writes and reads zero.
        wr(8'h6c, 4'h0, 32'hffff_ffff, 8'h00);
        rd_chk(8'h6c, scg_pkg::UNMAPPED_DATA);
        rd_chk(8'h68, dw(9'h0, 8'h80));
        // A bus reset clears the gates but keeps the latched cause.
        wr(8'h68, 4'b1100, 32'h0000_01ff, 8'h00);
        sbr();
        rd_chk(8'h68, dw(9'h000, 8'h80));
        wr(8'h68, 4'b1100, 32'h0000_01ff, 8'h00);
        $display("Test unmapped and bus reset done");
        // A mid-run reset restores the reset values.
        @(negedge sys_clk);
        arst_n = 1'b0;
        @(negedge sys_clk);
        chk32("sclk_rst", 32'h0, {27'h0, sec_clk_out});
        chk1("oe_rst", 1'b0, sys_err_oe);
        chk32("rdata_rst", 32'h0, cfg_rdata);
        chk1("rvalid_rst", 1'b0, cfg_rd_valid);
        arst_n = 1'b1;
        rd_chk(8'h68, dw(9'h000, 8'h00));
        $display("Test reset done");
        stop_test();
    end
endmodule : scg_bank_tb
`default_nettype wire
